// ==== shared/qrsc_defs.vh ====
`ifndef QRSC_DEFS_VH
`define QRSC_DEFS_VH
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define QRSC_ADDR_CTRL        8'h00
`define QRSC_ADDR_STATUS      8'h04
`define QRSC_ADDR_UDCNT       8'h08
`define QRSC_ADDR_FOLDBACK    8'h0C
`define QRSC_ADDR_ZCCNT       8'h10
// ----------------------------------------
// Control fields
// ----------------------------------------
`define QRSC_CTRL_ENABLE_BIT  0
`define QRSC_CTRL_LATCHCLR_BIT 1
`define QRSC_CTRL_RESET       32'h00000000
`define QRSC_UDCNT_RESET      3'h1
`define QRSC_UDCNT_MIN        3'h1
`define QRSC_UDCNT_MAX        3'h7
`define QRSC_XING_MAX         3'h7
// ----------------------------------------
// Status fields
// ----------------------------------------
`define QRSC_ST_GATE_BIT      0
`define QRSC_ST_BURST_BIT     1
`define QRSC_ST_BIAS_BIT      2
`define QRSC_ST_LATCH_BIT     3
// ----------------------------------------
// Timing, in ns, and cycles at 20 ns
// ----------------------------------------
`define QRSC_CLK_NS           20
`define QRSC_RS_LONG_NS       25000
`define QRSC_RS_SHORT_NS      2500
`define QRSC_OFFMAX_NS        50000
`define QRSC_LEB_NS           220
`define QRSC_ONMAX_NS         25000
`define QRSC_SW_BLANK_NS      200
`define QRSC_BEB_NS           20000000
`define QRSC_BURST_PER_NS     19231
`define QRSC_CEIL(t)          (((t) + `QRSC_CLK_NS - 1) / `QRSC_CLK_NS)
`define QRSC_FLOOR(t)         ((t) / `QRSC_CLK_NS)
`endif

// ==== src/qrsc_top.v ====
// Summary of operation
// - Outside burst, gate stays low for the whole ringing suppression interval after turn-off.
// - Long suppression interval when valley sense below threshold, short otherwise.
// - After suppression, turn on when valley count reaches up/down counter value.
// - Turn on after maximum off time regardless of counts.
// - Normal mode: scaled sense above feedback turns gate off.
// - Scaled sense equals sense times 3.3 plus 0.7; comparator is analog.
// - Switch-off comparator ignored during leading edge blanking after turn-on.
// - Gate forced off after maximum on time.
// - Peak current limit comparator turns gate off every cycle outside burst.
// - Peak limit comparator also masked during leading edge blanking.
// - Short-winding detect accepted only after persisting through its blank time.
// - Current limit lowered by offset from excess valley-pin current.
// - Burst entry after feedback low and counter at 7 for entry blank time.
// - In burst with switching idle, feedback above upper threshold restarts bias.
// - In burst, turn-on comes from fixed 52 kHz timer.
// - In burst, turn-off at burst sense limit or 50 percent duty.
// - In burst, feedback at lower threshold stops bias and switching.
// - Feedback above exit threshold leaves burst, foldback offset applies again, counter set to 1.
// - Short-winding detection while gate on latches the device off.
// - Up/down counter stays within 1 to 7; outside moves ignored.
// - Valley count increments per falling crossing, saturates at 7, clears at turn-on.
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`include "qrsc_defs.vh"

module qrsc_top #(
  parameter BEB_CYCLES    = `QRSC_FLOOR(`QRSC_BEB_NS),
  parameter RS_LONG_CYC   = `QRSC_CEIL(`QRSC_RS_LONG_NS),
  parameter RS_SHORT_CYC  = `QRSC_CEIL(`QRSC_RS_SHORT_NS),
  parameter OFFMAX_CYC    = `QRSC_FLOOR(`QRSC_OFFMAX_NS),
  parameter LEB_CYC       = `QRSC_CEIL(`QRSC_LEB_NS),
  parameter ONMAX_CYC     = `QRSC_FLOOR(`QRSC_ONMAX_NS),
  parameter SWB_CYC       = `QRSC_CEIL(`QRSC_SW_BLANK_NS),
  parameter BURST_PER_CYC = `QRSC_FLOOR(`QRSC_BURST_PER_NS)
) (
  input  wire        CLK_IN,
  input  wire        RESET_IN,
  // Comparator results from the analog front end
  input  wire        SENSE_ABOVE_FB_IN,       // Scaled sense above feedback
  input  wire        SENSE_ABOVE_LIMIT_IN,    // Sense above line-dependent peak limit
  input  wire        SENSE_ABOVE_SW_IN,       // Sense above short-winding threshold
  input  wire        SENSE_ABOVE_BURST_IN,    // Sense above burst sense limit
  input  wire        VALLEY_ABOVE_XING_IN,    // Valley sense above 100 mV crossing level
  input  wire        VALLEY_ABOVE_RS_IN,      // Valley sense above ringing select threshold
  input  wire        FB_BELOW_ENTRY_IN,       // Feedback below burst entry threshold
  input  wire        FB_ABOVE_UPPER_IN,       // Feedback above burst upper threshold
  input  wire        FB_BELOW_LOWER_IN,       // Feedback at or below burst lower threshold
  input  wire        FB_ABOVE_EXIT_IN,        // Feedback above burst exit threshold
  // AXI4-Lite slave
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output wire [1:0]  S_AXI_BRESP,
  output wire        S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0]  S_AXI_RRESP,
  output wire        S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  // Outputs
  output wire        GATE_OUT,
  output wire        BURST_OUT,
  output wire        BIAS_OUT,
  output wire        LATCH_OFF_OUT,
  output wire [7:0]  FOLDBACK_OFFSET_OUT
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam NIN = 10;
  wire [NIN-1:0] raw_in = {FB_ABOVE_EXIT_IN, FB_BELOW_LOWER_IN, FB_ABOVE_UPPER_IN,
                           FB_BELOW_ENTRY_IN, VALLEY_ABOVE_RS_IN, VALLEY_ABOVE_XING_IN,
                           SENSE_ABOVE_BURST_IN, SENSE_ABOVE_SW_IN, SENSE_ABOVE_LIMIT_IN,
                           SENSE_ABOVE_FB_IN};
  wire [NIN-1:0] sync_in;
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      // Two stages; only the second stage is used by the logic
      always @(posedge CLK_IN) begin
        if (RESET_IN) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= raw_in[gi];
          s2_q <= s1_q;
        end
      end
      assign sync_in[gi] = s2_q;
    end
  endgenerate

  wire cmp_fb     = sync_in[0];
  wire cmp_limit  = sync_in[1];
  wire cmp_sw     = sync_in[2];
  wire cmp_burst  = sync_in[3];
  wire xing_above = sync_in[4];
  wire rs_above   = sync_in[5];
  wire fb_entry   = sync_in[6];
  wire fb_upper   = sync_in[7];
  wire fb_lower   = sync_in[8];
  wire fb_exit    = sync_in[9];

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  reg  [31:0] ctrl_q;
  reg  [2:0]  udcnt_q;
  reg  [7:0]  fold_q;
  reg  [2:0]  zccnt_q;
  reg         gate_q;
  reg         burst_q;
  reg         bias_q;
  reg         latch_q;
  wire        enable = ctrl_q[`QRSC_CTRL_ENABLE_BIT];

  reg         aw_hold_q;
  reg  [7:0]  aw_addr_q;
  reg         w_hold_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         bvalid_q;
  reg  [1:0]  bresp_q;
  reg         rvalid_q;
  reg  [31:0] rdata_q;
  reg  [1:0]  rresp_q;

  assign S_AXI_AWREADY = ~aw_hold_q & ~bvalid_q;
  assign S_AXI_WREADY  = ~w_hold_q & ~bvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = ~rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;

  wire        wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
  wire        wr_ctrl = wr_fire & (aw_addr_q == `QRSC_ADDR_CTRL);
  wire        wr_ud   = wr_fire & (aw_addr_q == `QRSC_ADDR_UDCNT) & w_strb_q[0];
  wire        wr_fold = wr_fire & (aw_addr_q == `QRSC_ADDR_FOLDBACK) & w_strb_q[0];
  wire        wr_map  = (aw_addr_q == `QRSC_ADDR_CTRL) | (aw_addr_q == `QRSC_ADDR_UDCNT) |
                        (aw_addr_q == `QRSC_ADDR_FOLDBACK);
  wire        latch_clr = wr_ctrl & w_strb_q[0] & w_data_q[`QRSC_CTRL_LATCHCLR_BIT];
  integer     bi;

  // Write channel: address and data captured independently, response after both
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q  <= 1'b0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      ctrl_q    <= `QRSC_CTRL_RESET;
      fold_q    <= 8'h00;
    end else begin
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= {S_AXI_AWADDR[7:2], 2'h0};
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_hold_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_map ? 2'h0 : 2'h3;   // DECERR on unmapped
      end else if (bvalid_q & S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
      if (wr_ctrl) begin
        for (bi = 0; bi < 4; bi = bi + 1) begin
          if (w_strb_q[bi]) begin
            ctrl_q[bi*8 +: 8] <= w_data_q[bi*8 +: 8];
          end
        end
        ctrl_q[`QRSC_CTRL_LATCHCLR_BIT] <= 1'b0; // Self-clearing action bit
      end
      // Offset stands for excess valley-pin current, computed digitally upstream
      if (wr_fold) begin
        fold_q <= w_data_q[7:0];
      end
    end
  end

  // Read channel: one cycle to answer
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= 2'h0;
    end else if (S_AXI_ARVALID & S_AXI_ARREADY) begin
      rvalid_q <= 1'b1;
      rresp_q  <= 2'h0;
      case ({S_AXI_ARADDR[7:2], 2'h0})
        `QRSC_ADDR_CTRL:     rdata_q <= ctrl_q;
        `QRSC_ADDR_STATUS:   rdata_q <= {28'h0000000, latch_q, bias_q, burst_q, gate_q};
        `QRSC_ADDR_UDCNT:    rdata_q <= {29'h0000000, udcnt_q};
        `QRSC_ADDR_FOLDBACK: rdata_q <= {24'h000000, fold_q};
        `QRSC_ADDR_ZCCNT:    rdata_q <= {29'h0000000, zccnt_q};
        default: begin
          rdata_q <= 32'h00000000;
          rresp_q <= 2'h3;
        end
      endcase
    end else if (rvalid_q & S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Switching timers
  // ----------------------------------------
  reg  [31:0] off_cnt_q;
  reg  [31:0] on_cnt_q;
  reg  [31:0] rs_len_q;
  reg  [31:0] sw_cnt_q;
  reg  [31:0] beb_cnt_q;
  reg  [31:0] per_cnt_q;
  reg         xing_prev_q;

  wire        rs_done   = off_cnt_q >= rs_len_q;
  wire        off_max   = off_cnt_q >= OFFMAX_CYC;
  wire        leb_done  = on_cnt_q >= LEB_CYC;
  wire        on_max    = on_cnt_q >= ONMAX_CYC;
  wire        sw_hit    = gate_q & cmp_sw & (sw_cnt_q >= SWB_CYC - 1);
  wire        burst_tick = per_cnt_q >= BURST_PER_CYC - 1;
  wire        xing_fall = xing_prev_q & ~xing_above;

  // Turn-on and turn-off decisions; any off cause wins
  wire normal_on  = rs_done & ((zccnt_q >= udcnt_q) | off_max);
  wire normal_off = leb_done & (cmp_fb | cmp_limit);
  wire burst_off  = leb_done & cmp_burst;
  wire duty_off   = on_cnt_q >= (BURST_PER_CYC / 2);
  wire turn_off   = gate_q & (on_max | (burst_q ? (burst_off | duty_off)
                                                : normal_off));
  // Burst entry waits for the gate to be low, so no pulse runs with bias off
  wire entry_cond = fb_entry & (udcnt_q == `QRSC_UDCNT_MAX);
  wire burst_set  = ~burst_q & ~gate_q & entry_cond & (beb_cnt_q >= BEB_CYCLES - 1);
  // Low feedback blocks the burst timer, so bias never drops under a new pulse
  wire turn_on    = ~gate_q & enable & ~latch_q & ~burst_set &
                    (burst_q ? (bias_q & ~fb_lower & burst_tick) : normal_on);

  // Gate flip-flop and its on/off counters
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      gate_q    <= 1'b0;
      on_cnt_q  <= 32'h00000000;
      off_cnt_q <= 32'h00000000;
      rs_len_q  <= 32'h00000000;
    end else if (gate_q) begin
      on_cnt_q <= on_cnt_q + 32'h00000001;
      if (turn_off | sw_hit | latch_q | ~enable) begin
        gate_q    <= 1'b0;
        off_cnt_q <= 32'h00000000;
        rs_len_q  <= rs_above ? RS_SHORT_CYC : RS_LONG_CYC;
      end
    end else begin
      if (~rs_done | ~off_max) begin
        off_cnt_q <= off_cnt_q + 32'h00000001;
      end
      if (turn_on) begin
        gate_q   <= 1'b1;
        on_cnt_q <= 32'h00000000;
      end
    end
  end

  // Valley crossing counter and short-winding persistence
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      zccnt_q   <= 3'h0;
      xing_prev_q <= 1'b0;
      sw_cnt_q  <= 32'h00000000;
    end else begin
      xing_prev_q <= xing_above;
      if (gate_q) begin
        zccnt_q <= 3'h0;
      end else if (xing_fall & (zccnt_q != `QRSC_XING_MAX)) begin
        zccnt_q <= zccnt_q + 3'h1;
      end
      sw_cnt_q <= (gate_q & cmp_sw) ? sw_cnt_q + 32'h00000001 : 32'h00000000;
    end
  end

  // Latch-off; a new detection beats a software clear in the same cycle
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      latch_q <= 1'b0;
    end else if (sw_hit) begin
      latch_q <= 1'b1;
    end else if (latch_clr) begin
      latch_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Burst mode and up/down counter
  // ----------------------------------------
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      burst_q   <= 1'b0;
      bias_q    <= 1'b1;
      beb_cnt_q <= 32'h00000000;
      per_cnt_q <= 32'h00000000;
      udcnt_q   <= `QRSC_UDCNT_RESET;
    end else begin
      per_cnt_q <= (burst_tick | ~burst_q) ? 32'h00000000 : per_cnt_q + 32'h00000001;
      beb_cnt_q <= (entry_cond & ~burst_q) ? beb_cnt_q + 32'h00000001 : 32'h00000000;
      if (burst_q & fb_exit) begin
        burst_q <= 1'b0;
        bias_q  <= 1'b1;
        udcnt_q <= `QRSC_UDCNT_MIN;
      end else if (burst_q) begin
        if (~bias_q & fb_upper) begin
          bias_q <= 1'b1;
        end else if (bias_q & fb_lower & ~gate_q) begin
          bias_q <= 1'b0;
        end
      end else if (burst_set) begin
        burst_q <= 1'b1;
        bias_q  <= 1'b0;
      end else if (wr_ud) begin
        // Out-of-range values are ignored
        if ((w_data_q[2:0] >= `QRSC_UDCNT_MIN) & (w_data_q[31:3] == 29'h0000000)) begin
          udcnt_q <= w_data_q[2:0];
        end
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign GATE_OUT            = gate_q;
  assign BURST_OUT           = burst_q;
  assign BIAS_OUT            = bias_q;
  assign LATCH_OFF_OUT       = latch_q;
  // Full limit held in burst: offset only applies outside burst
  assign FOLDBACK_OFFSET_OUT = burst_q ? 8'h00 : fold_q;

endmodule // qrsc_top

// ==== dv/qrsc_plant.sv ====
`timescale 1ns/100ps
// ----
// Switch and sense model
// ----
module qrsc_plant (
  input  wire logic       clk_in,
  input  wire logic       gate_in,
  input  wire logic [1:0] sel_in,
  input  wire logic [7:0] len_in,
  input  wire logic       sw_in,
  input  wire logic       ring_in,
  output logic            fb_out,
  output logic            lim_out,
  output logic            sw_out,
  output logic            bst_out,
  output logic            xing_out
);
  logic [7:0] t_q = 8'h00;
  logic       g_q = 1'b0;
  logic       hit;
  // Time since the last gate edge, as the switch node sees it
  always @(posedge clk_in) begin
    g_q <= gate_in;
    t_q <= (gate_in != g_q) ? 8'h00 : t_q + 8'h01;
  end
  // Ramp crosses the chosen level len_in cycles into the on time
  assign hit     = gate_in && g_q && (t_q >= len_in);
  assign fb_out  = hit && (sel_in == 2'h0);
  assign lim_out = hit && (sel_in == 2'h1);
  assign bst_out = hit && (sel_in == 2'h2);
  assign sw_out  = gate_in && sw_in;
  // Ringing falls every 8 cycles; damped node never crosses
  assign xing_out = !gate_in && !g_q && ring_in && t_q[2];
endmodule // qrsc_plant

// ==== dv/qrsc_top_chk.sv ====
`timescale 1ns/100ps
// ----
// Gate timing checker
// ----
module qrsc_top_chk #(
  parameter RS_SHORT_CYC  = 125,
  parameter LEB_CYC       = 11,
  parameter ONMAX_CYC     = 1250,
  parameter SWB_CYC       = 10,
  parameter BEB_CYCLES    = 1000000,
  parameter BURST_PER_CYC = 961
) (
  input wire       CLK_IN,
  input wire       RESET_IN,
  input wire       SENSE_ABOVE_SW_IN,
  input wire       FB_BELOW_ENTRY_IN,
  input wire       FB_ABOVE_EXIT_IN,
  input wire       GATE_OUT,
  input wire       BURST_OUT,
  input wire       BIAS_OUT,
  input wire       LATCH_OFF_OUT,
  input wire [7:0] FOLDBACK_OFFSET_OUT
);
  localparam int DUTY_MAX = BURST_PER_CYC / 2 + 2;
  int on_q, off_q, sw_q, fbe_q;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  // Run lengths; raw inputs counted, so sync lag only adds margin
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      on_q  <= 0;
      off_q <= 0;
      sw_q  <= 0;
      fbe_q <= 0;
    end else begin
      on_q  <= GATE_OUT ? on_q + 1 : 0;
      off_q <= GATE_OUT ? 0 : off_q + 1;
      sw_q  <= SENSE_ABOVE_SW_IN ? sw_q + 1 : 0;
      fbe_q <= FB_BELOW_ENTRY_IN ? fbe_q + 1 : 0;
    end
  end
  a_ring_hold: assert property ($rose(GATE_OUT) |-> off_q >= RS_SHORT_CYC)
    else $error("gate rose inside ringing suppression");
  a_leb_min: assert property ($fell(GATE_OUT) && !LATCH_OFF_OUT |-> on_q >= LEB_CYC)
    else $error("gate fell inside leading edge blanking");
  a_onmax_cap: assert property (GATE_OUT |-> on_q <= ONMAX_CYC + 1)
    else $error("gate high past maximum on time");
  a_burst_duty: assert property (BURST_OUT && $rose(GATE_OUT) |-> ##[1:DUTY_MAX] !GATE_OUT)
    else $error("burst pulse past half period");
  a_sw_blank: assert property ($rose(LATCH_OFF_OUT) |-> sw_q >= SWB_CYC)
    else $error("latch set on a short spike");
  a_latch_gate: assert property (LATCH_OFF_OUT |=> !GATE_OUT)
    else $error("gate high while latched off");
  a_entry_wait: assert property ($rose(BURST_OUT) |-> fbe_q >= BEB_CYCLES)
    else $error("burst entered before blanking ran out");
  a_exit_burst: assert property (FB_ABOVE_EXIT_IN [*5] |-> !BURST_OUT)
    else $error("burst held with feedback above exit level");
  a_fold_zero: assert property (BURST_OUT && $past(BURST_OUT)
    |-> FOLDBACK_OFFSET_OUT == 8'h00) else $error("limit offset kept in burst");
  a_bias_gate: assert property (BURST_OUT && !BIAS_OUT |-> !GATE_OUT)
    else $error("gate high with burst bias off");
  c_burst: cover property ($rose(BURST_OUT));
  c_latch: cover property ($rose(LATCH_OFF_OUT));
  c_bpulse: cover property (BURST_OUT && $rose(GATE_OUT));
endmodule // qrsc_top_chk
bind qrsc_top qrsc_top_chk #(.RS_SHORT_CYC(RS_SHORT_CYC), .LEB_CYC(LEB_CYC),
  .ONMAX_CYC(ONMAX_CYC), .SWB_CYC(SWB_CYC), .BEB_CYCLES(BEB_CYCLES),
  .BURST_PER_CYC(BURST_PER_CYC)) i_qrsc_top_chk (.*);

// ==== dv/qrsc_top_test.sv ====
`timescale 1ns/100ps
module qrsc_top_test;
  localparam int LEB = 4, ONM = 40, OFM = 60, RSL = 20, RSS = 6, BEB = 50, BPER = 20;
  logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0, len = 15, fo;
  logic [31:0] wdata = 0, rdata, rd, v, ud;
  logic [1:0]  bresp, rresp, rs, sel = 0;
  logic awready, wready, bvalid, arready, rvalid, gate, burst, bias, latch;
  logic sw = 0, ring = 1, vrs = 1, fbe = 0, fbu = 0, fbl = 0, fbx = 0, fb, lim, swc, bst, xg;
  int n_mismatch = 0, compares = 0, seed = 22744, on_c = 0, off_c = 0;
  int last_on = 0, last_off = 0, rises = 0, r, i, l;
  always #10 clk = ~clk;
  qrsc_top #(.BEB_CYCLES(BEB), .RS_LONG_CYC(RSL), .RS_SHORT_CYC(RSS), .OFFMAX_CYC(OFM),
    .LEB_CYC(LEB), .ONMAX_CYC(ONM), .SWB_CYC(3), .BURST_PER_CYC(BPER)) i_qrsc_top (
    .CLK_IN(clk), .RESET_IN(rst), .SENSE_ABOVE_FB_IN(fb), .SENSE_ABOVE_LIMIT_IN(lim),
    .SENSE_ABOVE_SW_IN(swc), .SENSE_ABOVE_BURST_IN(bst), .VALLEY_ABOVE_XING_IN(xg),
    .VALLEY_ABOVE_RS_IN(vrs), .FB_BELOW_ENTRY_IN(fbe), .FB_ABOVE_UPPER_IN(fbu),
    .FB_BELOW_LOWER_IN(fbl), .FB_ABOVE_EXIT_IN(fbx), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .GATE_OUT(gate),
    .BURST_OUT(burst), .BIAS_OUT(bias), .LATCH_OFF_OUT(latch), .FOLDBACK_OFFSET_OUT(fo));
  qrsc_plant i_qrsc_plant (.clk_in(clk), .gate_in(gate), .sel_in(sel), .len_in(len),
    .sw_in(sw), .ring_in(ring), .fb_out(fb), .lim_out(lim), .sw_out(swc), .bst_out(bst),
    .xing_out(xg));
  // Gate timing monitor, mid-cycle so launching edges have settled
  always @(negedge clk) begin
    if (gate === 1'b1) begin
      if (off_c > 0) last_off = off_c;
      if (off_c > 0) rises++;
      off_c = 0;
      on_c++;
    end else begin
      if (on_c > 0) last_on = on_c;
      on_c = 0;
      off_c++;
    end
  end
  // ----
  // Checking and closing
  // ----
  task wrap_up;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) n_mismatch++;
    if (s !== e) $display("[FAIL] %0t seen %h expected %h", $time, s, e);
  endtask
  task tmo;
    n_mismatch++;
    $display("[FAIL] %0t wait ran out", $time);
    wrap_up;
  endtask
  // Earliest legal on time for a ramp that trips len_in cycles in
  function int lo_on(int x);
    return (x + 1 > LEB) ? x + 1 : LEB;
  endfunction
  // ----
  // AXI4-Lite master: ready seen mid-cycle, released after the edge
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, tb;
    n = 0;
    tb = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = (bvalid === 1'b1);
      rs = bresp;
      n++;
      if (n > 50) tmo;
      @(posedge clk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tb) bready <= 0;
    end
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    logic ta, tv;
    n = 0;
    tv = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!tv) begin
      @(negedge clk);
      ta = arvalid && arready;
      tv = (rvalid === 1'b1);
      rd = rdata;
      rs = rresp;
      n++;
      if (n > 50) tmo;
      @(posedge clk);
      if (ta) arvalid <= 0;
      if (tv) rready <= 0;
    end
  endtask
  function logic sig(int k);
    return k == 0 ? gate : k == 1 ? burst : k == 2 ? bias : latch;
  endfunction
  task automatic wt(input int k, input logic lv, input int lim);
    int n;
    n = 0;
    while (sig(k) !== lv) begin
      @(negedge clk);
      n++;
      if (n > lim) tmo;
    end
  endtask
  task pulses(input int n);
    repeat (n) begin
      wt(0, 1, OFM + 20);
      wt(0, 0, ONM + 20);
    end
    @(negedge clk);
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    rdr(8'h04); chk(rd, 32'h4);
    rdr(8'h08); chk(rd, 32'h1);
    rdr(8'h20); chk({rd[29:0], rs}, 32'h3);
    wr(8'h20, 32'h0); chk(rs, 2'h3);
    ud = 1;
    for (i = 0; i < 10; i++) begin
      v = (i < 2) ? i * 8 : $random(seed) & 15;
      wr(8'h08, v);
      if (v >= 1 && v <= 7) ud = v;
      rdr(8'h08); chk(rd, ud);
    end
    wr(8'h0C, 32'hA5);
    @(negedge clk); chk(fo, 8'hA5);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h1);
    for (i = 0; i < 5; i++) begin
      l = (i < 2) ? 0 : 8 + ($random(seed) & 7);
      @(posedge clk);
      sel <= i[0];
      len <= l[7:0];
      pulses(2); chk(last_on >= lo_on(l) && last_on <= lo_on(l) + 5, 1);
    end
    chk(last_off >= RSS + 1 && last_off <= 16, 1);
    r = last_off;
    wr(8'h08, 32'h4);
    pulses(2); chk(last_off >= r + 20 && last_off <= r + 28, 1);
    wr(8'h08, 32'h1);
    @(posedge clk); vrs <= 0;
    pulses(3); chk(last_off >= RSL && last_off <= RSL + 4, 1);
    @(posedge clk); vrs <= 1; ring <= 0;
    pulses(2); chk(last_off >= OFM && last_off <= OFM + 3, 1);
    @(posedge clk); ring <= 1; sel <= 3;
    pulses(2); chk(last_on >= ONM && last_on <= ONM + 2, 1);
    @(posedge clk); sel <= 0; sw <= 1;
    wt(3, 1, 200);
    r = rises;
    repeat (100) @(negedge clk);
    chk(rises, r);
    rdr(8'h10); chk(rd, 32'h7);
    @(posedge clk); sw <= 0;
    wr(8'h00, 32'h3);
    repeat (4) @(negedge clk);
    chk(latch, 1'b0);
    wr(8'h08, 32'h7);
    @(posedge clk); fbe <= 1;
    wt(1, 1, BEB + 150);
    wt(2, 0, 100);
    rdr(8'h04); chk(rd, 32'h2);
    chk(fo, 8'h00);
    @(posedge clk); fbe <= 0; fbu <= 1; sel <= 3;
    wt(2, 1, 20);
    pulses(3); chk(last_on + last_off >= BPER - 1 && last_on + last_off <= BPER + 1, 1);
    chk(last_on >= BPER / 2 - 1 && last_on <= BPER / 2 + 1, 1);
    @(posedge clk); sel <= 2; len <= 3;
    pulses(2); chk(last_on >= lo_on(3) && last_on <= lo_on(3) + 5, 1);
    @(posedge clk); fbu <= 0; fbl <= 1;
    wt(2, 0, BPER + 40);
    r = rises;
    repeat (60) @(negedge clk);
    chk(rises, r);
    @(posedge clk); fbl <= 0; fbx <= 1;
    wt(1, 0, 20);
    rdr(8'h08); chk(rd, 32'h1);
    chk(fo, 8'hA5);
    wrap_up;
  end
endmodule // qrsc_top_test
